// ===== core/lbs_defs.svh
// Constants for the logic, bit and left-shift execution block
//
// Functional notes
// - Complement inverts the operand, flags kept; negate stores inverse plus one, sets flags.
// - Accumulator test ANDs byte or word accumulator with immediate; only flags change.
// - Accumulator AND writes result back to byte or word accumulator by size bit.
// - OR register/memory forms store OR; direction bit picks the destination.
// - Immediate AND/OR/XOR share one opcode; reg field 100, 001, 110 selects.
// - Logical ops clear carry and excess, set parity/sign/zero, aux undefined.
// - Bit test sets zero when selected bit is 0, clears carry/excess, stores nothing.
// - Bit number comes from count register or 3/4-bit immediate by width.
// - Bit invert flips only the selected bit and leaves all flags unchanged.
// - Bit clear forces selected bit to 0, number from count register, flags kept.
// - Bit set from count register forces selected bit to 1, flags kept.
// - Immediate bit set uses 3-bit byte or 4-bit word immediate bit number.
// - Shift by one moves MSB to carry, doubles, excess is new MSB xor carry.
// - Count shift repeats one-bit shift while count copy nonzero; carry is last out.
// - Immediate-count shift takes an 8-bit repeat count from the instruction.
// - Shift group shares opcodes; reg field 100 selects the left shift.
`ifndef LBS_DEFS_SVH
`define LBS_DEFS_SVH
// ==========================================
// Register byte offsets
`define LBS_ADR_INSTR   8'h00
`define LBS_ADR_OPER    8'h04
`define LBS_ADR_ACC     8'h08
`define LBS_ADR_COUNT   8'h0C
`define LBS_ADR_FLAGS   8'h10
`define LBS_ADR_CTRL    8'h14
`define LBS_ADR_STATUS  8'h18
// ==========================================
// Opcode patterns
`define LBS_OP_TEST_RM  7'h42
`define LBS_OP_TEST_AC  7'h54
`define LBS_OP_GRP3     7'h7B
`define LBS_OP_AND_RM   6'h08
`define LBS_OP_OR_RM    6'h02
`define LBS_OP_XOR_RM   6'h0C
`define LBS_OP_AND_AC   7'h12
`define LBS_OP_OR_AC    7'h06
`define LBS_OP_XOR_AC   7'h1A
`define LBS_OP_GRP1     7'h40
`define LBS_OP_PREFIX   8'h0F
`define LBS_OP_BITGRP   4'h1
`define LBS_OP_CY_NOT   8'hF5
`define LBS_OP_CY_CLR   8'hF8
`define LBS_OP_CY_SET   8'hF9
`define LBS_OP_DIR_CLR  8'hFC
`define LBS_OP_DIR_SET  8'hFD
`define LBS_OP_SH_ONE   7'h68
`define LBS_OP_SH_CL    7'h69
`define LBS_OP_SH_IMM   7'h60
`define LBS_RF_AND      3'h4
`define LBS_RF_OR       3'h1
`define LBS_RF_XOR      3'h6
`define LBS_RF_TEST     3'h0
`define LBS_RF_NOT      3'h2
`define LBS_RF_NEG      3'h3
`define LBS_RF_SHL      3'h4
`define LBS_FLAGS_RST   7'h00
`endif

// ===== core/lbs_pkg.sv
// Types shared by the logic, bit and left-shift execution block
package lbs_pkg;
   // Flag word, bit 0 upward: carry, parity, aux, zero, sign, dir, excess
   typedef struct packed {
      logic excess;
      logic dir;
      logic sign;
      logic zero;
      logic aux;
      logic parity;
      logic carry;
   } lbs_flags_t;
   // Instruction bytes as fetched, first byte lowest
   typedef struct packed {
      logic [7:0] imm;
      logic [7:0] op2;
      logic [7:0] op1;
      logic [7:0] op0;
   } lbs_instr_t;
   typedef enum logic [4:0] {
      OP_NONE, OP_TEST, OP_AND, OP_OR, OP_XOR, OP_NOT, OP_NEG,
      OP_BTST, OP_BCLR, OP_BSET, OP_BNOT, OP_CNOT, OP_CCLR, OP_CSET,
      OP_DCLR, OP_DSET, OP_SHL
   } lbs_op_t;
   typedef enum logic [1:0] {DST_NONE, DST_RM, DST_REG, DST_ACC} lbs_dst_t;
   typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_SHIFT} lbs_state_t;
endpackage

// ===== core/lbs_exec.sv
// Wishbone-attached logic, bit and left-shift execution unit
//
// Chosen here: the register addresses and the Wishbone register port.
`timescale 1ns/10ps
`include "lbs_defs.svh"
module lbs_exec
   import lbs_pkg::*;
(
   input  wire logic        CLOCK,     // 25 MHz core clock
   input  wire logic        ARST_N,    // Async reset, low active
   input  wire logic        WB_CYC_I,  // Bus cycle
   input  wire logic        WB_STB_I,  // Strobe
   input  wire logic        WB_WE_I,   // Write enable
   input  wire logic [7:0]  WB_ADR_I,  // Byte address
   input  wire logic [3:0]  WB_SEL_I,  // Byte lanes
   input  wire logic [31:0] WB_DAT_I,  // Write data
   output logic      [31:0] WB_DAT_O,  // Read data
   output logic             WB_ACK_O   // Acknowledge
);
   // ==========================================
   // Helpers
   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
      for (int i = 0; i < 4; i++) begin
         o[i*8 +: 8] = s[i] ? n[i*8 +: 8] : o[i*8 +: 8];
      end
      return o;
   endfunction
   function automatic logic msb(input logic [15:0] v, input logic w);
      return w ? v[15] : v[7];
   endfunction
   function automatic logic [15:0] fit(input logic [15:0] a, input logic [15:0] r, input logic w);
      return w ? r : {a[15:8], r[7:0]};
   endfunction
   // Parity, sign and zero from a result, carry and excess cleared
   function automatic lbs_flags_t lflags(input lbs_flags_t f, input logic [15:0] r, input logic w);
      f.carry  = 1'b0;
      f.excess = 1'b0;
      f.parity = ~^r[7:0];
      f.sign   = msb(r, w);
      f.zero   = w ? (r == 16'h0000) : (r[7:0] == 8'h00);
      return f;
   endfunction

   // ==========================================
   // Registers
   lbs_instr_t  instr;
   logic [31:0] oper;
   logic [15:0] acc;
   logic [7:0]  cnt_reg;
   lbs_flags_t  flags;
   logic [15:0] result;
   lbs_dst_t    dest;
   logic        done;
   logic        unsup;
   lbs_state_t  state;
   logic [15:0] work;
   logic [7:0]  cnt;
   logic        shcy;
   logic        shv;
   logic        ack;
   logic [31:0] rdat;

   // ==========================================
   // Bus decode
   wire         req     = WB_CYC_I & WB_STB_I & ~ack;
   wire         wr      = req & WB_WE_I;
   wire         idle    = (state == ST_IDLE);
   wire         wr_ok   = wr & idle;
   wire         start   = wr_ok & (WB_ADR_I == `LBS_ADR_CTRL) & WB_SEL_I[0] & WB_DAT_I[0];
   wire [31:0]  status  = {11'h000, unsup, dest, done, ~idle, result};
   wire [31:0]  flagw   = {25'h0000000, flags};
   wire [31:0]  rd_mux  = (WB_ADR_I == `LBS_ADR_INSTR)  ? instr :
                          (WB_ADR_I == `LBS_ADR_OPER)   ? oper :
                          (WB_ADR_I == `LBS_ADR_ACC)    ? {16'h0000, acc} :
                          (WB_ADR_I == `LBS_ADR_COUNT)  ? {24'h000000, cnt_reg} :
                          (WB_ADR_I == `LBS_ADR_FLAGS)  ? flagw :
                          (WB_ADR_I == `LBS_ADR_STATUS) ? status : 32'h00000000;

   // ==========================================
   // Instruction decode
   wire         pfx   = (instr.op0 == `LBS_OP_PREFIX) & (instr.op1[7:4] == `LBS_OP_BITGRP);
   wire [7:0]   modrm = pfx ? instr.op2 : instr.op1;
   wire [2:0]   rf    = modrm[5:3];
   wire         w     = pfx ? instr.op1[0] : instr.op0[0];
   wire [6:0]   o7    = instr.op0[7:1];
   wire [5:0]   o6    = instr.op0[7:2];
   wire         dbit  = instr.op0[1];
   wire         rmfm  = (o6 == `LBS_OP_AND_RM) | (o6 == `LBS_OP_OR_RM) | (o6 == `LBS_OP_XOR_RM);
   wire         accfm = (o7 == `LBS_OP_AND_AC) | (o7 == `LBS_OP_OR_AC) | (o7 == `LBS_OP_XOR_AC);
   wire         shfm  = (o7 == `LBS_OP_SH_ONE) | (o7 == `LBS_OP_SH_CL) | (o7 == `LBS_OP_SH_IMM);
   wire [2:0]   lsel  = accfm ? {instr.op0[5:4] == 2'b10, instr.op0[5:4] == 2'b00, instr.op0[5:4] == 2'b11} :
                        rmfm  ? {o6 == `LBS_OP_AND_RM, o6 == `LBS_OP_OR_RM, o6 == `LBS_OP_XOR_RM} :
                        {rf == `LBS_RF_AND, rf == `LBS_RF_OR, rf == `LBS_RF_XOR};
   wire         lgfm  = accfm | rmfm | (o7 == `LBS_OP_GRP1);
   wire lbs_op_t lgop = lsel[2] ? OP_AND : lsel[1] ? OP_OR : lsel[0] ? OP_XOR : OP_NONE;
   wire [1:0]   bsub  = instr.op1[2:1];
   wire lbs_op_t bop  = (bsub == 2'b00) ? OP_BTST : (bsub == 2'b01) ? OP_BCLR :
                        (bsub == 2'b10) ? OP_BSET : OP_BNOT;
   // Operation select
   wire lbs_op_t op   = pfx ? bop :
                        lgfm ? lgop :
                        ((o7 == `LBS_OP_TEST_RM) | (o7 == `LBS_OP_TEST_AC)) ? OP_TEST :
                        (o7 == `LBS_OP_GRP3) ? ((rf == `LBS_RF_TEST) ? OP_TEST :
                                                (rf == `LBS_RF_NOT) ? OP_NOT :
                                                (rf == `LBS_RF_NEG) ? OP_NEG : OP_NONE) :
                        (instr.op0 == `LBS_OP_CY_NOT)  ? OP_CNOT :
                        (instr.op0 == `LBS_OP_CY_CLR)  ? OP_CCLR :
                        (instr.op0 == `LBS_OP_CY_SET)  ? OP_CSET :
                        (instr.op0 == `LBS_OP_DIR_CLR) ? OP_DCLR :
                        (instr.op0 == `LBS_OP_DIR_SET) ? OP_DSET :
                        (shfm & (rf == `LBS_RF_SHL)) ? OP_SHL : OP_NONE;
   // Operand A is the accumulator for accumulator forms, else the r/m operand
   wire         accop = accfm | (o7 == `LBS_OP_TEST_AC);
   wire [15:0]  opa   = accop ? acc : oper[15:0];
   wire [15:0]  opb   = (accop & ~w) ? {8'h00, oper[23:16]} : oper[31:16];
   // Bit number, low 3 bits for bytes and 4 for words
   wire [3:0]   bsrc  = instr.op1[3] ? instr.imm[3:0] : cnt_reg[3:0];
   wire [3:0]   bnum  = w ? bsrc : {1'b0, bsrc[2:0]};
   wire [15:0]  mask  = 16'h0001 << bnum;
   // Shift repeat count
   wire [7:0]   scnt  = (o7 == `LBS_OP_SH_ONE) ? 8'h01 :
                        (o7 == `LBS_OP_SH_CL) ? cnt_reg : instr.imm;
   wire         sh_end = (cnt == 8'h00);
   wire [15:0]  sh_nxt = work << 1;

   // ==========================================
   // Single-cycle execute
   logic [15:0] next_res;
   lbs_flags_t  next_flags;
   lbs_dst_t    next_dest;
   always_comb begin
      next_res   = opa;
      next_flags = flags;
      next_dest  = accop ? DST_ACC : (dbit & rmfm) ? DST_REG : DST_RM;
      unique case (op)
         OP_TEST: begin
            next_res   = opa & opb;
            next_flags = lflags(flags, opa & opb, w);
            next_dest  = DST_NONE;
         end
         OP_AND: begin
            next_res   = opa & opb;
            next_flags = lflags(flags, opa & opb, w);
         end
         OP_OR: begin
            next_res   = opa | opb;
            next_flags = lflags(flags, opa | opb, w);
         end
         OP_XOR: begin
            next_res   = opa ^ opb;
            next_flags = lflags(flags, opa ^ opb, w);
         end
         OP_NOT: next_res = ~opa;
         OP_NEG: begin
            next_res          = ~opa + 16'h0001;
            next_flags        = lflags(flags, ~opa + 16'h0001, w);
            next_flags.carry  = w ? (opa != 16'h0000) : (opa[7:0] != 8'h00);
            next_flags.excess = w ? (opa == 16'h8000) : (opa[7:0] == 8'h80);
            next_flags.aux    = (opa[3:0] != 4'h0);
         end
         OP_BTST: begin
            next_flags.zero   = ~|(opa & mask);
            next_flags.carry  = 1'b0;
            next_flags.excess = 1'b0;
            next_dest         = DST_NONE;
         end
         OP_BCLR: next_res = opa & ~mask;
         OP_BSET: next_res = opa | mask;
         OP_BNOT: next_res = opa ^ mask;
         OP_CNOT: next_flags.carry = ~flags.carry;
         OP_CCLR: next_flags.carry = 1'b0;
         OP_CSET: next_flags.carry = 1'b1;
         OP_DCLR: next_flags.dir = 1'b0;
         OP_DSET: next_flags.dir = 1'b1;
         default: next_dest = DST_NONE;
      endcase
      if (op >= OP_CNOT) begin
         next_dest = DST_NONE;
      end
   end

   // ==========================================
   // Bus slave: one-cycle acknowledge, registered read data
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         ack  <= 1'b0;
         rdat <= 32'h00000000;
      end else begin
         ack  <= req;
         rdat <= req ? rd_mux : 32'h00000000;
      end
   end
   assign WB_ACK_O = ack;
   assign WB_DAT_O = rdat;

   // Operand registers, written by software only while idle
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         instr   <= '0;
         oper    <= 32'h00000000;
         cnt_reg <= 8'h00;
      end else if (wr_ok) begin
         if (WB_ADR_I == `LBS_ADR_INSTR) instr <= merge(instr, WB_DAT_I, WB_SEL_I);
         if (WB_ADR_I == `LBS_ADR_OPER) oper <= merge(oper, WB_DAT_I, WB_SEL_I);
         if ((WB_ADR_I == `LBS_ADR_COUNT) & WB_SEL_I[0]) cnt_reg <= WB_DAT_I[7:0];
      end
   end

   // Accumulator and flags: hardware update wins over a software write
   wire [31:0] accw = merge({16'h0000, acc}, WB_DAT_I, WB_SEL_I);
   wire [31:0] flgm = merge(flagw, WB_DAT_I, WB_SEL_I);
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         acc   <= 16'h0000;
         flags <= `LBS_FLAGS_RST;
      end else if (state == ST_EXEC) begin
         if (op != OP_SHL) flags <= next_flags;
         if ((op != OP_SHL) & (next_dest == DST_ACC)) acc <= fit(acc, next_res, w);
      end else if ((state == ST_SHIFT) & sh_end & (scnt != 8'h00)) begin
         flags        <= lflags(flags, work, w);
         flags.carry  <= shcy;
         flags.excess <= shv;
      end else if (wr_ok) begin
         if (WB_ADR_I == `LBS_ADR_ACC) acc <= accw[15:0];
         if (WB_ADR_I == `LBS_ADR_FLAGS) flags <= flgm[6:0];
      end
   end

   // ==========================================
   // Sequencer: execute in one cycle, shift one bit per cycle
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         state  <= ST_IDLE;
         result <= 16'h0000;
         dest   <= DST_NONE;
         done   <= 1'b0;
         unsup  <= 1'b0;
         work   <= 16'h0000;
         cnt    <= 8'h00;
         shcy   <= 1'b0;
         shv    <= 1'b0;
      end else begin
         unique case (state)
            ST_IDLE: if (start) begin
               state <= ST_EXEC;
               done  <= 1'b0;
            end
            ST_EXEC: begin
               unsup <= (op == OP_NONE);
               if (op == OP_SHL) begin
                  state <= ST_SHIFT;
                  work  <= opa;
                  cnt   <= scnt;
                  shcy  <= flags.carry;
                  shv   <= flags.excess;
                  dest  <= (scnt == 8'h00) ? DST_NONE : DST_RM;
               end else begin
                  state  <= ST_IDLE;
                  done   <= 1'b1;
                  result <= fit(opa, next_res, w);
                  dest   <= next_dest;
               end
            end
            ST_SHIFT: if (sh_end) begin
               state  <= ST_IDLE;
               done   <= 1'b1;
               result <= fit(oper[15:0], work, w);
            end else begin
               work <= sh_nxt;
               shcy <= msb(work, w);
               shv  <= msb(sh_nxt, w) ^ msb(work, w);
               cnt  <= cnt - 8'h01;
            end
         endcase
      end
   end

   // ==========================================
   // Checks
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!ARST_N);
   wire exec     = (state == ST_EXEC);
   wire work_msb = msb(work, w);  // Bit leaving the operand on this shift step
   a_ack_single: assert property (ack |=> !ack) else $error("ack held too long");
   a_ack_answer: assert property (req |=> ack) else $error("request not answered");
   a_not_flags: assert property (exec && op == OP_NOT |=> flags == $past(flags))
      else $error("complement moved flags");
   a_neg_value: assert property (exec && op == OP_NEG && w |=> result == 16'h0000 - $past(opa))
      else $error("negate result wrong");
   a_logic_clear: assert property (exec && (op == OP_XOR || op == OP_OR || op == OP_AND)
      |=> !flags.carry && !flags.excess) else $error("logic op left carry");
   a_btst_zero: assert property (exec && op == OP_BTST
      |=> flags.zero == ~|($past(opa) & $past(mask)) && dest == DST_NONE) else $error("bit test zero wrong");
   a_bset_bit: assert property (exec && op == OP_BSET
      |=> (result & $past(mask)) != 16'h0000 && flags == $past(flags)) else $error("bit set failed");
   a_bclr_bit: assert property (exec && op == OP_BCLR |=> (result & $past(mask)) == 16'h0000)
      else $error("bit clear failed");
   a_bnot_bit: assert property (exec && op == OP_BNOT |=> (result ^ $past(opa)) == $past(mask))
      else $error("bit invert wrong");
   a_shl_carry: assert property (state == ST_SHIFT && !sh_end |=> shcy == $past(work_msb))
      else $error("shift carry wrong");
   a_shl_zero: assert property (exec && op == OP_SHL && scnt == 8'h00 |=> ##1 flags == $past(flags, 2))
      else $error("zero shift changed flags");
   c_shift_run: cover property (state == ST_SHIFT ##1 state == ST_SHIFT ##1 state == ST_SHIFT);
   c_bit_invert: cover property (exec && op == OP_BNOT);
   c_acc_and: cover property (exec && op == OP_AND && accop);
   c_bus_write: cover property (ack && WB_WE_I);
endmodule

// ===== test/tb_logic_bit_shift_exec.sv
// Self-checking bench for the logic, bit and left-shift execution block
`timescale 1ns/10ps
`include "lbs_defs.svh"
module tb_logic_bit_shift_exec
   import lbs_pkg::*;
;
   // ==========================================
   // Signals and scoreboard
   typedef struct {logic c; logic [31:0] e; logic [31:0] m;} lbs_note_t;
   logic        CLOCK = 1'b0;
   logic        ARST_N, wb_cyc, wb_stb, wb_we, WB_ACK_O;
   logic [7:0]  wb_adr;
   logic [3:0]  wb_sel;
   logic [31:0] wb_dat, WB_DAT_O, op, q, sd;
   logic [15:0] a, b, acc, r;
   logic [7:0]  cnt, im;
   logic [22:0] s;
   lbs_flags_t  f0, g;
   lbs_note_t   notes[$];
   int          error_cnt, checks_done, cycles, k, j;
   int          rf[3] = '{4, 1, 6};
   logic [7:0]  cd[5] = '{8'hF5, 8'hF8, 8'hF9, 8'hFC, 8'hFD};

   lbs_exec i_dut (
      .CLOCK    (CLOCK),
      .ARST_N   (ARST_N),
      .WB_CYC_I (wb_cyc),
      .WB_STB_I (wb_stb),
      .WB_WE_I  (wb_we),
      .WB_ADR_I (wb_adr),
      .WB_SEL_I (wb_sel),
      .WB_DAT_I (wb_dat),
      .WB_DAT_O (WB_DAT_O),
      .WB_ACK_O (WB_ACK_O)
   );

   // Clock at 25 MHz
   always #20 CLOCK = ~CLOCK;

   // ==========================================
   // Helpers
   // Verdict and end of run
   task automatic end_sim;
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Random source, 32 shifts per draw to decorrelate values
   function automatic logic [31:0] nx(input logic [31:0] x);
      for (int i = 0; i < 32; i++) x = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
      return x;
   endfunction

   // Flags after a logical operation, aux left as it was
   function automatic lbs_flags_t lgf(input logic [15:0] v, input logic w, input lbs_flags_t o);
      lbs_flags_t f;
      f = o;
      f.carry = 1'b0;
      f.excess = 1'b0;
      f.zero = w ? (v == 16'h0) : (v[7:0] == 8'h0);
      f.sign = w ? v[15] : v[7];
      f.parity = ~^v[7:0];
      return f;
   endfunction

   // Left shift repeated n times: {flags, result}
   function automatic logic [22:0] shm(input logic [15:0] x, input logic w, input logic [7:0] n,
                                       input lbs_flags_t f);
      logic [15:0] v;
      logic        c;
      lbs_flags_t  h;
      v = x;
      h = f;
      for (int i = 0; i < n; i++) begin
         c = w ? v[15] : v[7];
         v = w ? {v[14:0], 1'b0} : {x[15:8], v[6:0], 1'b0};
         h = lgf(v, w, h);
         h.carry = c;
         h.excess = (w ? v[15] : v[7]) ^ c;
      end
      return {h, v};
   endfunction

   // One classic Wishbone cycle; a note for the monitor is queued first
   task automatic bus(input logic we, input logic [7:0] ad, input logic [31:0] d, input logic [3:0] sl,
                      input logic c, input logic [31:0] e, input logic [31:0] m, output logic [31:0] rq);
      lbs_note_t n;
      n.c = c;
      n.e = e;
      n.m = m;
      notes.push_back(n);
      @(posedge CLOCK);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we  <= we;
      wb_adr <= ad;
      wb_dat <= d;
      wb_sel <= sl;
      do @(posedge CLOCK); while (WB_ACK_O !== 1'b1);
      rq = WB_DAT_O;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we  <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] ad, input logic [31:0] d);
      bus(1'b1, ad, d, 4'hF, 1'b0, 32'h0, 32'h0, q);
   endtask

   task automatic chk(input logic [7:0] ad, input logic [31:0] e, input logic [31:0] m);
      bus(1'b0, ad, 32'h0, 4'hF, 1'b1, e, m, q);
   endtask

   // Load operands, start, wait for done, then check status, flags and accumulator
   task automatic run(input logic [31:0] ins, input logic [15:0] er, input logic [1:0] ed, input lbs_flags_t ef,
                      input logic [6:0] fm, input logic rm, input logic [15:0] ea);
      logic [31:0] rq;
      wr(`LBS_ADR_INSTR, ins);
      wr(`LBS_ADR_OPER, op);
      wr(`LBS_ADR_ACC, {16'h0, acc});
      wr(`LBS_ADR_COUNT, {24'h0, cnt});
      wr(`LBS_ADR_FLAGS, {25'h0, f0});
      wr(`LBS_ADR_CTRL, 32'h1);
      do bus(1'b0, `LBS_ADR_STATUS, 32'h0, 4'hF, 1'b0, 32'h0, 32'h0, rq); while (rq[17] !== 1'b1);
      chk(`LBS_ADR_STATUS, {11'h0, 1'b0, ed, 2'b10, er}, {16'hFFFF, {16{rm}}});
      chk(`LBS_ADR_FLAGS, {25'h0, ef}, {25'h0, fm});
      chk(`LBS_ADR_ACC, {16'h0, ea}, 32'h0000FFFF);
   endtask

   // ==========================================
   // Monitor: each acknowledge retires the oldest note
   always @(posedge CLOCK) begin
      if (WB_ACK_O === 1'b1) begin
         if (notes.size() == 0) begin
            error_cnt++;
            $display("FAIL %0t acknowledge without request", $time);
         end else if (notes[0].c) begin
            checks_done++;
            if ((WB_DAT_O & notes[0].m) !== (notes[0].e & notes[0].m)) begin
               error_cnt++;
               $display("FAIL %0t read %h expected %h mask %h", $time, WB_DAT_O, notes[0].e, notes[0].m);
            end
            void'(notes.pop_front());
         end else begin
            void'(notes.pop_front());
         end
      end
   end

   // Hang guard
   always @(posedge CLOCK) begin
      cycles++;
      if (cycles > 60000) begin
         error_cnt++;
         $display("FAIL %0t timeout", $time);
         end_sim();
      end
   end

   // ==========================================
   // Main sequence
   initial begin
      ARST_N <= 1'b0;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we  <= 1'b0;
      wb_adr <= 8'h00;
      wb_sel <= 4'h0;
      wb_dat <= 32'h0;
      sd = 32'h4B96390F;
      error_cnt = 0;
      checks_done = 0;
      cycles = 0;
      repeat (12) @(posedge CLOCK);
      ARST_N <= 1'b1;
      chk(`LBS_ADR_FLAGS, 32'h0, 32'hFFFFFFFF);
      chk(`LBS_ADR_STATUS, 32'h0, 32'hFFFFFFFF);
      wr(8'h1C, 32'hFFFFFFFF);
      chk(8'h1C, 32'h0, 32'hFFFFFFFF);
      chk(`LBS_ADR_CTRL, 32'h0, 32'hFFFFFFFF);
      wr(`LBS_ADR_OPER, 32'hFFFFFFFF);
      bus(1'b1, `LBS_ADR_OPER, 32'h00001234, 4'h3, 1'b0, 32'h0, 32'h0, q);
      chk(`LBS_ADR_OPER, 32'hFFFF1234, 32'hFFFFFFFF);
      for (k = 0; k < 4; k++) begin
         sd = nx(sd);
         op = sd;
         sd = nx(sd);
         acc = sd[15:0];
         cnt = sd[23:16];
         im = sd[31:24];
         sd = nx(sd);
         f0 = sd[6:0];
         if (k == 0) begin
            cnt = 8'h00;
            im = 8'h00;
         end
         a = op[15:0];
         b = op[31:16];
         run(32'h0000D0F7, ~a, 2'd1, f0, 7'h7F, 1'b1, acc);
         r = {a[15:8], 8'(~a[7:0] + 8'h01)};
         g = lgf(r, 1'b0, f0);
         g.carry = a[7:0] != 8'h0;
         g.excess = a[7:0] == 8'h80;
         g.aux = a[3:0] != 4'h0;
         run(32'h0000D8F6, r, 2'd1, g, 7'h7F, 1'b1, acc);
         run(32'h000000A8, 16'h0, 2'd0, lgf({8'h0, acc[7:0] & b[7:0]}, 1'b0, f0), 7'h7F, 1'b0, acc);
         run(32'h000000A9, 16'h0, 2'd0, lgf(acc & b, 1'b1, f0), 7'h7F, 1'b0, acc);
         r = acc & b;
         run(32'h00000025, r, 2'd3, lgf(r, 1'b1, f0), 7'h7F, 1'b1, r);
         r = {acc[15:8], acc[7:0] & b[7:0]};
         run(32'h00000024, r, 2'd3, lgf(r, 1'b0, f0), 7'h7F, 1'b1, r);
         r = a | b;
         run(32'h0000C00B, r, 2'd2, lgf(r, 1'b1, f0), 7'h7F, 1'b1, acc);
         run(32'h0000C009, r, 2'd1, lgf(r, 1'b1, f0), 7'h7F, 1'b1, acc);
         for (j = 0; j < 3; j++) begin
            r = rf[j] == 4 ? a & b : rf[j] == 1 ? a | b : a ^ b;
            run({16'h0, 2'b11, 3'(rf[j]), 3'b000, 8'h81}, r, 2'd1, lgf(r, 1'b1, f0), 7'h7F, 1'b1, acc);
         end
         r = a ^ b;
         run(32'h0000C031, r, 2'd1, lgf(r, 1'b1, f0), 7'h7F, 1'b1, acc);
         g = f0;
         g.carry = 1'b0;
         g.excess = 1'b0;
         g.zero = ~a[cnt[2:0]];
         run(32'h00C0100F, 16'h0, 2'd0, g, 7'h6D, 1'b0, acc);
         g.zero = ~a[im[3:0]];
         run({im, 24'hC0190F}, 16'h0, 2'd0, g, 7'h6D, 1'b0, acc);
         run(32'h00C0160F, a ^ (16'h1 << cnt[2:0]), 2'd1, f0, 7'h7F, 1'b1, acc);
         run({im, 24'hC01F0F}, a ^ (16'h1 << im[3:0]), 2'd1, f0, 7'h7F, 1'b1, acc);
         run(32'h00C0130F, a & ~(16'h1 << cnt[3:0]), 2'd1, f0, 7'h7F, 1'b1, acc);
         run(32'h00C0140F, a | (16'h1 << cnt[2:0]), 2'd1, f0, 7'h7F, 1'b1, acc);
         run({im, 24'hC01C0F}, a | (16'h1 << im[2:0]), 2'd1, f0, 7'h7F, 1'b1, acc);
         run({im, 24'hC01D0F}, a | (16'h1 << im[3:0]), 2'd1, f0, 7'h7F, 1'b1, acc);
         s = shm(a, 1'b1, 8'h01, f0);
         run(32'h0000E0D1, s[15:0], 2'd1, s[22:16], 7'h7F, 1'b1, acc);
         s = shm(a, 1'b1, cnt, f0);
         run(32'h0000E0D3, s[15:0], (cnt == 8'h00) ? 2'd0 : 2'd1, s[22:16], 7'h7F, 1'b1, acc);
         s = shm(a, 1'b0, im, f0);
         run({im, 24'h00E0C0}, s[15:0], (im == 8'h00) ? 2'd0 : 2'd1, s[22:16], 7'h7F, 1'b1, acc);
         for (j = 0; j < 5; j++) begin
            g = f0;
            case (j)
               0: g.carry = ~f0.carry;
               1: g.carry = 1'b0;
               2: g.carry = 1'b1;
               3: g.dir = 1'b0;
               default: g.dir = 1'b1;
            endcase
            run({24'h0, cd[j]}, 16'h0, 2'd0, g, 7'h7F, 1'b0, acc);
         end
      end
      // A rotate shares the shift opcode; it is flagged unsupported and leaves the flags alone
      wr(`LBS_ADR_INSTR, 32'h0000C0D1);
      wr(`LBS_ADR_CTRL, 32'h1);
      do bus(1'b0, `LBS_ADR_STATUS, 32'h0, 4'hF, 1'b0, 32'h0, 32'h0, q); while (q[17] !== 1'b1);
      chk(`LBS_ADR_STATUS, 32'h00120000, 32'hFFFF0000);
      chk(`LBS_ADR_FLAGS, {25'h0, g}, 32'h0000007F);
      // Writes while a long shift is running are acknowledged but dropped
      wr(`LBS_ADR_INSTR, 32'h0000E0D3);
      wr(`LBS_ADR_COUNT, 32'h000000FF);
      wr(`LBS_ADR_ACC, 32'h00001111);
      wr(`LBS_ADR_CTRL, 32'h1);
      chk(`LBS_ADR_STATUS, 32'h00010000, 32'h00030000);
      wr(`LBS_ADR_ACC, 32'h00005A5A);
      do bus(1'b0, `LBS_ADR_STATUS, 32'h0, 4'hF, 1'b0, 32'h0, 32'h0, q); while (q[17] !== 1'b1);
      chk(`LBS_ADR_ACC, 32'h00001111, 32'h0000FFFF);
      end_sim();
   end
endmodule
